// [src/high_speed_channel_output_sequencer.sv]
// The implementer's own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ns
// Behaviour
// [R1] Modifier bit taken with the function strobe, command code one period later.
// [R2] Operand commands collect four nibbles of accumulator data over four periods.
// [R3] Command 0 starts clear-channel; command 5 starts the address-ready sequence.
// [R4] Operand is block length (5), address (2/3) or pointer and buffer (16); the code takes pointer and buffer with CMD_PARAM = 4'he (14).
// [R5] Clear-channel only when address-request is low; otherwise await command 5.
// [R6] Remote raises address-request when ready, drops it after three strobes.
// [R7] Accepting address-request resets the readout counter and enables address strobes.
// [R8] Address strobes need command 5 and address-request; select, mode, advance first.
// [R9] Each address strobe carries a 16-bit slice plus 4 parity bits.
// [R10] Block length goes to output control eight bits at a time.
// [R11] Grab latches the block length; it is held and decremented through the transfer.
// [R12] Address sequence start issues buffer-clear and serial parameter-select to the buffer.
// [R13] Parameter-select stream: four buffer bits first, then the A/B pointer bit.
// [R14] Remote sends a credit whenever it can accept sixteen more words.
// [R15] Words flow only after a credit, one credit per sixteen words.
// [R16] One data-ready per word: every 6 periods at 200 MB, 12 at 100 MB.
// [R17] Each data-ready also decrements length, pulses parameter-select and data-advance.
// [R18] Parameter-select reaches the buffer only ANDed with data-advance.
// [R19] Last-word flag goes with the final data-ready when the length hits zero.
// [R20] Done sets when length is zero and address-request is active.
// [R21] Remote re-raises address-request only after an error-free write.
// [R22] Remote reports address parity and data SECDED errors.
// [R23] Three-strobe format slice layout of address and block length.
// [R24] Five-strobe format nibble layout of address and block length.
// [R25] After reset: idle, no strobes, done clear, length zero.
module high_speed_channel_output_sequencer
  import hsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic fn_go_i,
  input wire logic [3:0] fn_data_i,
  input wire logic xmit_addr_i,
  input wire logic xmit_data_i,
  input wire logic addr_par_err_i,
  input wire logic secded_err_i,
  output logic clear_channel_o,
  output logic addr_ready_o,
  output logic [15:0] addr_lines_o,
  output logic [3:0] addr_parity_o,
  output logic sel_buf_a_o,
  output logic mode100_o,
  output logic data_ready_o,
  output logic last_word_o,
  output logic buf_clear_o,
  output logic buf_param_o,
  output logic done_o
);
  import hsc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [8:0] meta_ff;
  logic [8:0] sync_ff;
  logic go_q_ff;
  logic xd_q_ff;
  logic go_s, xa_s, xd_s, perr_s, serr_s;
  logic [3:0] fd_s;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= 9'h000;
      sync_ff <= 9'h000;
      go_q_ff <= 1'b0;
      xd_q_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= {secded_err_i, addr_par_err_i, xmit_data_i, xmit_addr_i, fn_data_i, fn_go_i};
      sync_ff <= meta_ff;
      go_q_ff <= go_s;
      xd_q_ff <= xd_s;
    end
  end

  assign go_s = sync_ff[0];
  assign fd_s = sync_ff[4:1];
  assign xa_s = sync_ff[5];
  assign xd_s = sync_ff[6];
  assign perr_s = sync_ff[7];
  assign serr_s = sync_ff[8];

  // ---------------------------------------------------------------
  // Function decode
  // ---------------------------------------------------------------
  logic [2:0] fn_ph_ff;
  logic mod_ff;
  logic [3:0] cmd_ff;
  logic [15:0] opnd_ff;
  logic exec_ff;
  logic go_rise;

  function automatic logic needs_operand(input logic [3:0] c);
    return c == CMD_ADDR_LO || c == CMD_ADDR_HI || c == CMD_START || c == CMD_PARAM;
  endfunction : needs_operand

  assign go_rise = go_s && !go_q_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fn_ph_ff <= 3'h0;
      mod_ff <= 1'b0;
      cmd_ff <= 4'h0;
      opnd_ff <= 16'h0000;
      exec_ff <= 1'b0;
    end
    else
    begin
      exec_ff <= 1'b0;
      case (fn_ph_ff)
        3'h0:
        begin
          if (go_rise)
          begin
            mod_ff <= fd_s[0]; // [R1]
            fn_ph_ff <= 3'h1;
          end
        end
        3'h1:
        begin
          cmd_ff <= fd_s; // [R1]
          if (needs_operand(fd_s))
            fn_ph_ff <= 3'h2;
          else
          begin
            fn_ph_ff <= 3'h0;
            exec_ff <= 1'b1;
          end
        end
        default:
        begin
          opnd_ff <= {fd_s, opnd_ff[15:4]}; // [R2]
          if (fn_ph_ff == 3'(OPERAND_NIBBLES + 1))
          begin
            fn_ph_ff <= 3'h0;
            exec_ff <= 1'b1;
          end
          else
            fn_ph_ff <= fn_ph_ff + 3'h1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Command operands
  // ---------------------------------------------------------------
  logic [31:0] addr_ff;
  logic [15:0] len_op_ff;
  logic [4:0] psel_ff;
  logic start_pend_ff;
  seq_state_e state_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_ff <= 32'h0;
      len_op_ff <= 16'h0000;
      psel_ff <= 5'h00;
    end
    else if (exec_ff)
    begin
      case (cmd_ff)
        CMD_START: len_op_ff <= opnd_ff; // [R4]
        CMD_ADDR_LO: addr_ff[15:0] <= opnd_ff; // [R4]
        CMD_ADDR_HI: addr_ff[31:16] <= opnd_ff; // [R4]
        CMD_PARAM: psel_ff <= opnd_ff[4:0]; // [R4]
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      clear_channel_o <= 1'b0; // [R25]
    else
      clear_channel_o <= exec_ff && cmd_ff == CMD_CLEAR && !xa_s; // [R3] [R5]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_pend_ff <= 1'b0;
    else if (exec_ff && cmd_ff == CMD_START)
      start_pend_ff <= 1'b1; // [R3]
    else if (state_ff == ST_IDLE && xa_s)
      start_pend_ff <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Control register and pace divider
  // ---------------------------------------------------------------
  logic [1:0] ctrl_ff;
  logic [3:0] pace_ff;
  logic tick;
  logic [3:0] pace_last;

  assign pace_last = ctrl_ff[CTRL_MODE100_BIT] ? 4'(PACE_100 - 1) : 4'(PACE_200 - 1);
  assign tick = pace_ff == 4'h0;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_ff == ST_IDLE || state_ff == ST_AR_SETUP || tick)
      pace_ff <= pace_last; // [R16]
    else
      pace_ff <= pace_ff - 4'h1;
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [2:0] sub_ff;
  logic [2:0] slice_ff;
  logic [2:0] n_slices;
  logic [15:0] blk_ff;
  logic [9:0] credit_ff;
  logic word_go;
  logic advance;
  logic ar_clear;
  logic done_ff;

  assign n_slices = ctrl_ff[CTRL_FIVE_BIT] ? 3'(SLICES_5) : 3'(SLICES_3);
  assign advance = state_ff == ST_AR_SEND && tick && slice_ff != n_slices;
  assign ar_clear = state_ff == ST_IDLE && start_pend_ff && xa_s; // [R7] [R8]
  assign word_go = state_ff == ST_DATA && tick && credit_ff != 10'h0 && blk_ff != 16'h0; // [R15] [R16]

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_ff <= ST_IDLE; // [R25]
      sub_ff <= 3'h0;
      slice_ff <= 3'h0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          sub_ff <= 3'h0;
          slice_ff <= 3'h0;
          if (ar_clear)
            state_ff <= ST_AR_SETUP; // [R8]
        end
        ST_AR_SETUP:
        begin
          sub_ff <= sub_ff + 3'h1;
          if (sub_ff == 3'(PSEL_BITS - 1))
            state_ff <= ST_AR_SEND;
        end
        ST_AR_SEND:
        begin
          if (advance)
            slice_ff <= slice_ff + 3'h1;
          if (slice_ff == n_slices && !addr_ready_o)
            state_ff <= ST_DATA;
        end
        ST_DATA:
        begin
          if (blk_ff == 16'h0)
            state_ff <= ST_FINISH;
        end
        ST_FINISH:
        begin
          if (xa_s)
            state_ff <= ST_IDLE; // [R20]
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // Strobes toward the remote device
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_ready_o <= 1'b0;
      data_ready_o <= 1'b0;
      last_word_o <= 1'b0;
    end
    else
    begin
      addr_ready_o <= advance; // [R7] [R9]
      data_ready_o <= word_go; // [R16]
      last_word_o <= word_go && blk_ff == 16'h1; // [R19]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_buf_a_o <= 1'b0;
      mode100_o <= 1'b0;
    end
    else
    begin
      sel_buf_a_o <= state_ff == ST_AR_SETUP || state_ff == ST_AR_SEND; // [R8]
      mode100_o <= (state_ff == ST_AR_SETUP || state_ff == ST_AR_SEND) && ctrl_ff[CTRL_MODE100_BIT]; // [R8]
    end
  end

  // Credit counter: sixteen words per credit
  always_ff @(posedge clk_i)
  begin
    if (rst_i || state_ff == ST_IDLE)
      credit_ff <= 10'h0;
    else
      credit_ff <= credit_ff + ((xd_s && !xd_q_ff) ? 10'(WORDS_PER_CREDIT) : 10'h0)
                   - (word_go ? 10'h1 : 10'h0); // [R14] [R15]
  end

  // ---------------------------------------------------------------
  // Output control: length counter and buffer board controls
  // ---------------------------------------------------------------
  logic [7:0] blk_byte;
  logic psel_bit_ff;
  logic adv_data_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      blk_ff <= 16'h0000; // [R25]
    else if (state_ff == ST_AR_SETUP && sub_ff == 3'h1)
      blk_ff[7:0] <= blk_byte; // [R11]
    else if (state_ff == ST_AR_SETUP && sub_ff == 3'h2)
      blk_ff[15:8] <= blk_byte; // [R10] [R11]
    else if (word_go)
      blk_ff <= blk_ff - 16'h1; // [R11] [R17]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      buf_clear_o <= 1'b0;
      psel_bit_ff <= 1'b0;
      adv_data_ff <= 1'b0;
    end
    else
    begin
      buf_clear_o <= state_ff == ST_AR_SETUP && sub_ff == 3'h0; // [R12]
      psel_bit_ff <= state_ff == ST_AR_SETUP ? psel_ff[sub_ff] : word_go; // [R12] [R13] [R17]
      adv_data_ff <= state_ff == ST_AR_SETUP || word_go; // [R17]
    end
  end

  assign buf_param_o = psel_bit_ff && adv_data_ff; // [R18]

  always_ff @(posedge clk_i)
  begin
    if (rst_i || (exec_ff && cmd_ff == CMD_START))
      done_ff <= 1'b0; // [R25]
    else if (state_ff == ST_FINISH && blk_ff == 16'h0 && xa_s)
      done_ff <= 1'b1; // [R20]
  end

  assign done_o = done_ff;

  address_readout_module u_readout (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clear_cnt_i(ar_clear),
    .advance_i(advance),
    .sel_buf_a_i(sel_buf_a_o),
    .five_i(ctrl_ff[CTRL_FIVE_BIT]),
    .addr_i(addr_ff),
    .blk_i(len_op_ff),
    .byte_sel_i(sub_ff != 3'h0),
    .slice_o(addr_lines_o),
    .parity_o(addr_parity_o),
    .blk_byte_o(blk_byte)
  );

  // ---------------------------------------------------------------
  // Wishbone slave
  // ---------------------------------------------------------------
  logic apar_ff, serr_ff;
  logic wr_en;

  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_ff <= CTRL_RESET;
    else if (wr_en && wb_adr_i == REG_CTRL && state_ff == ST_IDLE)
      ctrl_ff <= wb_dat_i[1:0];
  end

  // Error flags: a new report wins over a write-one clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      apar_ff <= 1'b0;
      serr_ff <= 1'b0;
    end
    else
    begin
      apar_ff <= perr_s || (apar_ff && !(wr_en && wb_adr_i == REG_STATUS && wb_dat_i[ST_APAR_BIT])); // [R22]
      serr_ff <= serr_s || (serr_ff && !(wr_en && wb_adr_i == REG_STATUS && wb_dat_i[ST_SECDED_BIT])); // [R22]
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
    begin
      case (wb_adr_i)
        REG_CTRL: wb_dat_o <= {30'h0, ctrl_ff};
        REG_STATUS: wb_dat_o <= {26'h0, mod_ff, start_pend_ff, serr_ff, apar_ff,
                                 state_ff != ST_IDLE, done_ff};
        REG_BLKLEN: wb_dat_o <= {16'h0, blk_ff};
        REG_ADDR: wb_dat_o <= addr_ff;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [3:0] since_dr_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i || data_ready_o)
      since_dr_ff <= 4'h1;
    else if (since_dr_ff != 4'hf)
      since_dr_ff <= since_dr_ff + 4'h1;
  end

  property p_cmd_take;
    @(posedge clk_i) disable iff (rst_i) fn_ph_ff == 3'h1 |=> cmd_ff == $past(fd_s);
  endproperty
  a_cmd_take: assert property (p_cmd_take) else $error("command code not taken"); // [R1]

  property p_operand_len;
    @(posedge clk_i) disable iff (rst_i)
      fn_ph_ff == 3'h2 |-> ##1 fn_ph_ff == 3'h3 ##1 fn_ph_ff == 3'h4 ##1 fn_ph_ff == 3'h5 ##1 exec_ff;
  endproperty
  a_operand_len: assert property (p_operand_len) else $error("operand not four periods"); // [R2]

  property p_clear_gate;
    @(posedge clk_i) disable iff (rst_i) clear_channel_o |-> $past(!xa_s) && $past(cmd_ff) == CMD_CLEAR;
  endproperty
  a_clear_gate: assert property (p_clear_gate) else $error("clear with request active"); // [R5]

  property p_setup_cause;
    @(posedge clk_i) disable iff (rst_i)
      state_ff == ST_AR_SETUP && $past(state_ff) == ST_IDLE |-> $past(xa_s && start_pend_ff);
  endproperty
  a_setup_cause: assert property (p_setup_cause) else $error("address sequence without cause"); // [R8]

  property p_pace200;
    @(posedge clk_i) disable iff (rst_i)
      data_ready_o && !ctrl_ff[CTRL_MODE100_BIT] |=> !data_ready_o [*5];
  endproperty
  a_pace200: assert property (p_pace200) else $error("data ready faster than 6"); // [R16]

  property p_pace_any;
    @(posedge clk_i) disable iff (rst_i)
      data_ready_o && $past(data_ready_o, 1) == 1'b0 && since_dr_ff != 4'hf |-> since_dr_ff == 4'(pace_last + 1);
  endproperty
  a_pace_any: assert property (p_pace_any) else $error("data ready spacing wrong"); // [R16]

  property p_credit;
    @(posedge clk_i) disable iff (rst_i) data_ready_o |-> $past(credit_ff) != 10'h0;
  endproperty
  a_credit: assert property (p_credit) else $error("word without credit"); // [R15]

  property p_last;
    @(posedge clk_i) disable iff (rst_i) last_word_o |-> data_ready_o && blk_ff == 16'h0;
  endproperty
  a_last: assert property (p_last) else $error("last word flag misplaced"); // [R19]

  property p_done;
    @(posedge clk_i) disable iff (rst_i) $rose(done_ff) |-> $past(blk_ff == 16'h0 && xa_s);
  endproperty
  a_done: assert property (p_done) else $error("done set without cause"); // [R20]

  property p_param_and;
    @(posedge clk_i) disable iff (rst_i) buf_param_o && state_ff == ST_DATA |-> $past(word_go);
  endproperty
  a_param_and: assert property (p_param_and) else $error("parameter select without advance"); // [R18]

endmodule : high_speed_channel_output_sequencer

// [src/hsc_pkg.sv]
package hsc_pkg;

  // ---------------------------------------------------------------
  // Function commands
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_CLEAR = 4'h0;
  localparam logic [3:0] CMD_ADDR_LO = 4'h2;
  localparam logic [3:0] CMD_ADDR_HI = 4'h3;
  localparam logic [3:0] CMD_START = 4'h5;
  localparam logic [3:0] CMD_PARAM = 4'he;
  localparam int OPERAND_NIBBLES = 4;

  // ---------------------------------------------------------------
  // Timing and sizes
  // ---------------------------------------------------------------
  localparam int PACE_200 = 6;
  localparam int PACE_100 = 12;
  localparam int WORDS_PER_CREDIT = 16;
  localparam int SLICES_3 = 3;
  localparam int SLICES_5 = 5;
  localparam int PSEL_BITS = 5;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_BLKLEN = 4'h8;
  localparam logic [3:0] REG_ADDR = 4'hc;
  localparam int CTRL_MODE100_BIT = 0;
  localparam int CTRL_FIVE_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int ST_DONE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_APAR_BIT = 2;
  localparam int ST_SECDED_BIT = 3;
  localparam int ST_PEND_BIT = 4;
  localparam int ST_MOD_BIT = 5;

  typedef enum logic [2:0] {ST_IDLE, ST_AR_SETUP, ST_AR_SEND, ST_DATA, ST_FINISH} seq_state_e;

endpackage : hsc_pkg

// [src/address_readout_module.sv]
`timescale 1ns/1ns
module address_readout_module
  import hsc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic clear_cnt_i,
  input wire logic advance_i,
  input wire logic sel_buf_a_i,
  input wire logic five_i,
  input wire logic [31:0] addr_i,
  input wire logic [15:0] blk_i,
  input wire logic byte_sel_i,
  output logic [15:0] slice_o,
  output logic [3:0] parity_o,
  output logic [7:0] blk_byte_o
);
  import hsc_pkg::*;

  logic [2:0] cnt_ff;
  logic [15:0] slice_ff;
  logic [7:0] byte_ff;
  logic [15:0] nxt_slice;

  // ---------------------------------------------------------------
  // Slice layout
  // ---------------------------------------------------------------
  function automatic logic [15:0] slice_of(input logic [2:0] k, input logic five,
                                           input logic [31:0] ad, input logic [15:0] bl);
    logic [15:0] s;
    s = 16'h0000;
    if (!five)
    begin
      case (k)
        3'h0: s = {ad[9], ad[31:17]};
        3'h1: s = {ad[13:10], ad[16], ad[8:0], bl[13:12]};
        3'h2: s = {2'h0, ad[15:14], bl[11:0]};
        default: s = 16'h0000;
      endcase
    end
    else
    begin
      s[3:0] = ad[4*k +: 4];
      if (k < 3'h3)
        s[7:4] = ad[20 + 4*k +: 4];
      if (k < 3'h4)
        s[11:8] = bl[4*k +: 4];
    end
    return s;
  endfunction : slice_of

  assign nxt_slice = slice_of(cnt_ff, five_i, addr_i, blk_i); // [R23] [R24]

  // ---------------------------------------------------------------
  // Readout counter and output lines
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_cnt_i)
      cnt_ff <= 3'h0; // [R7]
    else if (advance_i && sel_buf_a_i)
      cnt_ff <= cnt_ff + 3'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      slice_ff <= 16'h0000;
    else if (advance_i && sel_buf_a_i)
      slice_ff <= nxt_slice; // [R9]
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      byte_ff <= 8'h00;
    else
      byte_ff <= byte_sel_i ? blk_i[15:8] : blk_i[7:0]; // [R10]
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_par
      assign parity_o[g] = ~^slice_ff[4*g +: 4]; // [R9]
    end
  endgenerate

  assign slice_o = slice_ff;
  assign blk_byte_o = byte_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_cnt_clear;
    @(posedge clk_i) disable iff (rst_i) clear_cnt_i |=> cnt_ff == 3'h0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("readout counter not cleared"); // [R7]

  property p_first_slice3;
    @(posedge clk_i) disable iff (rst_i)
      advance_i && sel_buf_a_i && !clear_cnt_i && cnt_ff == 3'h0 && !five_i
      |=> slice_o == {$past(addr_i[9]), $past(addr_i[31:17])};
  endproperty
  a_first_slice3: assert property (p_first_slice3) else $error("first slice layout wrong"); // [R23]

  property p_five_low;
    @(posedge clk_i) disable iff (rst_i)
      advance_i && sel_buf_a_i && !clear_cnt_i && five_i && cnt_ff == 3'h4
      |=> slice_o == {12'h000, $past(addr_i[19:16])};
  endproperty
  a_five_low: assert property (p_five_low) else $error("fifth slice layout wrong"); // [R24]

endmodule : address_readout_module

// [sim/remote_model.sv]
`timescale 1ns/1ns
module remote_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic addr_ready_i,
  input wire logic data_ready_i,
  input wire logic last_word_i,
  output logic xmit_addr_o,
  output logic xmit_data_o
);
  logic [2:0] ar_cnt_ff;
  logic [3:0] dr_cnt_ff;
  logic due_ff;
  // ---------------------------------------------------------------
  // Address request and credits
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      xmit_addr_o <= 1'b1;
      xmit_data_o <= 1'b0;
      ar_cnt_ff <= 3'h0;
      dr_cnt_ff <= 4'h0;
      due_ff <= 1'b0;
    end
    else
    begin
      xmit_data_o <= due_ff;
      due_ff <= 1'b0;
      if (addr_ready_i)
        ar_cnt_ff <= ar_cnt_ff + 3'h1;
      if (addr_ready_i && ar_cnt_ff == 3'h2)
      begin
        xmit_addr_o <= 1'b0;
        due_ff <= 1'b1;
      end
      if (data_ready_i)
        dr_cnt_ff <= dr_cnt_ff + 4'h1;
      if (data_ready_i && dr_cnt_ff == 4'hf)
        due_ff <= 1'b1;
      if (last_word_i)
      begin
        xmit_addr_o <= 1'b1;
        ar_cnt_ff <= 3'h0;
        dr_cnt_ff <= 4'h0;
      end
    end
  end
endmodule : remote_model

// [sim/high_speed_channel_output_sequencer_tb_top.sv]
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module high_speed_channel_output_sequencer_tb_top;
  import hsc_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fn_go = 1'b0, ape = 1'b0, sde = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0, fn_d = 4'h0, ap;
  logic [31:0] dw = 32'h0, dr_q, q;
  logic ack, xa, xd, clr, ar, sba, m100, dr, lw, bc, bp, done;
  logic exp_m100 = 1'b0;
  logic [15:0] al, slice1;
  int fails = 0, n_tests = 0, t = 0, n_ar = 0, n_dr = 0, n_lw = 0, n_clr = 0, n_bc = 0, n_bp = 0, last = 0, gap = 0;
  high_speed_channel_output_sequencer high_speed_channel_output_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr_q),
    .wb_ack_o(ack), .fn_go_i(fn_go), .fn_data_i(fn_d), .xmit_addr_i(xa), .xmit_data_i(xd), .addr_par_err_i(ape),
    .secded_err_i(sde), .clear_channel_o(clr), .addr_ready_o(ar), .addr_lines_o(al), .addr_parity_o(ap),
    .sel_buf_a_o(sba), .mode100_o(m100), .data_ready_o(dr), .last_word_o(lw), .buf_clear_o(bc),
    .buf_param_o(bp), .done_o(done));
  remote_model remote_model_inst (.clk_i(clk_i), .rst_i(rst_i), .addr_ready_i(ar), .data_ready_i(dr),
    .last_word_i(lw), .xmit_addr_o(xa), .xmit_data_o(xd));
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  // ---------------------------------------------------------------
  // Monitor and timeout
  // ---------------------------------------------------------------
  always @(posedge clk_i)
  begin
    t++;
    if (ar)
    begin
      if (n_ar == 0) slice1 = al;
      n_ar++;
      `CHK({sba, m100, ap[0]}, {1'b1, exp_m100, ~^al[3:0]})
    end
    if (dr)
    begin
      n_dr++;
      gap = t - last;
      last = t;
    end
    if (lw) n_lw++;
    if (lw) `CHK(dr, 1'b1)
    if (clr) n_clr++;
    if (bc) n_bc++;
    if (bp) n_bp++;
    if (t == 20000)
    begin
      fails++;
      report_and_stop();
    end
  end
  task report_and_stop();
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dw, sel} <= {2'b11, w, a, d, 4'hf};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dr_q;
    {cyc, stb, we} <= 3'b000;
    @(posedge clk_i);
  endtask : wb
  task fn(input logic [3:0] c, input logic [15:0] op, input int n);
    @(posedge clk_i);
    fn_go <= 1'b1;
    fn_d <= 4'h0;
    @(posedge clk_i);
    fn_d <= c;
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk_i);
      fn_d <= op[4*i +: 4];
    end
    @(posedge clk_i);
    fn_go <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask : fn
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task t_regs();
    `CHK({done, ar, dr, clr, bc}, 5'h0)
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_DONE_BIT], 1'b0)
    wb(1'b0, REG_BLKLEN, 32'h0);
    `CHK(q[15:0], 16'h0)
    wb(1'b0, 4'h2, 32'h0);
    `CHK(q, 32'h0)
    wb(1'b1, REG_CTRL, 32'h3);
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK(q[1:0], 2'h3)
    wb(1'b1, REG_CTRL, 32'h0);
  endtask : t_regs
  task t_transfer();
    fn(CMD_ADDR_LO, 16'h0200, OPERAND_NIBBLES);
    fn(CMD_ADDR_HI, 16'h8002, OPERAND_NIBBLES);
    fn(CMD_PARAM, 16'h0013, OPERAND_NIBBLES);
    fn(CMD_CLEAR, 16'h0, 0);
    `CHK(n_clr, 0)
    fn(CMD_START, 16'h0003, OPERAND_NIBBLES);
    for (int k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk_i);
    `CHK(done, 1'b1)
    `CHK(n_ar, SLICES_3)
    `CHK(slice1, 16'hc001)
    `CHK(n_dr, 3)
    `CHK(gap, PACE_200)
    `CHK(n_lw, 1)
    `CHK(n_bc, 1)
    `CHK(n_bp, 6)
    wb(1'b0, REG_BLKLEN, 32'h0);
    `CHK(q[15:0], 16'h0)
  endtask : t_transfer
  task t_slow();
    wb(1'b1, REG_CTRL, 32'h3);
    exp_m100 = 1'b1;
    n_ar = 0;
    n_dr = 0;
    n_lw = 0;
    fn(CMD_START, 16'h0002, OPERAND_NIBBLES);
    for (int k = 0; k < 2000 && done !== 1'b1; k++) @(posedge clk_i);
    `CHK(done, 1'b1)
    `CHK(n_ar, SLICES_5)
    `CHK(slice1, 16'h0200)
    `CHK(n_dr, 2)
    `CHK(gap, PACE_100)
    `CHK(n_lw, 1)
    wb(1'b1, REG_CTRL, 32'h0);
    exp_m100 = 1'b0;
  endtask : t_slow
  task t_error();
    ape <= 1'b1;
    sde <= 1'b1;
    repeat (4) @(posedge clk_i);
    ape <= 1'b0;
    sde <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_APAR_BIT], 1'b1)
    `CHK(q[ST_SECDED_BIT], 1'b1)
    wb(1'b1, REG_STATUS, 32'hc);
    wb(1'b0, REG_STATUS, 32'h0);
    `CHK(q[ST_APAR_BIT], 1'b0)
    `CHK(q[ST_SECDED_BIT], 1'b0)
  endtask : t_error
  initial
  begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_transfer();
    t_slow();
    t_error();
    report_and_stop();
  end
endmodule : high_speed_channel_output_sequencer_tb_top
